/* File: hdl/charger_regs_map.vh */
`ifndef CHARGER_REGS_MAP_VH
`define CHARGER_REGS_MAP_VH
// register offsets
`define ADDR_THERM_CTRL      8'h0F
`define ADDR_FLOAT_VOLT      8'h11
`define ADDR_CHARGE_CURR     8'h12
// reset values
`define RST_THERM_CTRL       8'h40
`define RST_FLOAT_VOLT       8'h00
`define RST_CHARGE_CURR      8'h10
// control register field positions
`define BIT_SOFT_RESET       7
`define BIT_TREG_HI          6
`define BIT_TREG_LO          5
`define BIT_SHIP_AUTO        2
`define BIT_SWITCH_OFF       1
`define BIT_CHARGE_DIS       0
// charge current field
`define CURR_MSB             5
`define CURR_MAX_CODE        6'h3D
// writable masks (reserved bits excluded)
`define MASK_THERM_CTRL      8'h67
`define MASK_CHARGE_CURR     8'h3F
`endif

/* File: hdl/reg_store.v */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// eight-bit storage word with masked write and registered read data
// ----------------------------------------------------------------------
module reg_store #(
  parameter [7:0] RST_VAL = 8'h00,
  parameter [7:0] WMASK   = 8'hFF
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire       ce,
  input  wire       soft_rst,
  input  wire       wr,
  input  wire [7:0] wdata,
  output reg  [7:0] q
);

  // masked write; reserved bits keep their reset value
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= RST_VAL;
    end else if (ce) begin
      if (soft_rst) begin
        q <= RST_VAL;
      end else if (wr) begin
        q <= (wdata & WMASK) | (RST_VAL & ~WMASK);
      end
    end
  end

endmodule // reg_store
`default_nettype wire

/* File: hdl/charger_control_register_bank.v */
// Summary of operation
// - writing one to bit 7 resets registers
// - writing zero does nothing; reads zero
// - threshold code 00..11 selects 70/85/100/120C
// - auto entry sets switch off on undervoltage
// - writing one turns pass switch off immediately
// - switch off forbids supplemental mode
// - auto entry: source connect clears both bits
// - no auto entry: connect/removal clears switch off
// - charge disable opens switch, supplement still allowed
// - current code 0.2A+50mA steps, 3Dh up max
`timescale 1ns/10ps
`default_nettype none
`include "charger_regs_map.vh"
module charger_control_register_bank (
  input  wire       CORE_CLK,
  input  wire       RSTN,
  input  wire       CE,
  input  wire       WR_EN,
  input  wire       RD_EN,
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       BUS_BELOW_FALL,
  input  wire       IN_BELOW_FALL,
  input  wire       SOURCE_VALID,
  input  wire       SYS_BELOW_BAT,
  output reg  [7:0] RDATA,
  output reg        BATTERY_PASS_SWITCH_ON,
  output reg        SUPPLEMENT_ALLOWED,
  output reg  [1:0] THERMAL_REGULATION_THRESHOLD,
  output reg  [7:0] FLOAT_VOLTAGE_SETTING,
  output reg  [5:0] FAST_CHARGE_CURRENT
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  reg [3:0] sync_a;
  reg [3:0] sync_b;
  reg       valid_d;
  wire [3:0] pins = {SYS_BELOW_BAT, SOURCE_VALID, IN_BELOW_FALL, BUS_BELOW_FALL};

  // two flops per asynchronous pin
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync_a  <= 4'h0;
      sync_b  <= 4'h0;
      valid_d <= 1'b0;
    end else if (CE) begin
      sync_a  <= pins;
      sync_b  <= sync_a;
      valid_d <= sync_b[2];
    end
  end

  wire below_fall  = sync_b[0] | sync_b[1];
  wire src_connect = sync_b[2] & ~valid_d;
  wire src_remove  = ~sync_b[2] & valid_d;
  wire sys_low     = sync_b[3];

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  wire wr_ctrl  = WR_EN & hit(ADDR, `ADDR_THERM_CTRL);
  wire wr_float = WR_EN & hit(ADDR, `ADDR_FLOAT_VOLT);
  wire wr_curr  = WR_EN & hit(ADDR, `ADDR_CHARGE_CURR);
  wire soft_rst = wr_ctrl & WDATA[`BIT_SOFT_RESET];

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  reg [7:0] ctrl;
  reg [7:0] next_ctrl;

  // hardware events take priority over same-cycle software writes other than soft reset
  always @* begin
    next_ctrl = ctrl;
    if (soft_rst) begin
      next_ctrl = `RST_THERM_CTRL;
    end else begin
      if (wr_ctrl) begin
        next_ctrl = WDATA & `MASK_THERM_CTRL;
      end
      if (next_ctrl[`BIT_SHIP_AUTO] || ctrl[`BIT_SHIP_AUTO]) begin
        if (ctrl[`BIT_SHIP_AUTO] && below_fall) begin
          next_ctrl[`BIT_SWITCH_OFF] = 1'b1;
        end
      end
      if (ctrl[`BIT_SHIP_AUTO]) begin
        if (src_connect) begin
          next_ctrl[`BIT_SWITCH_OFF] = 1'b0;
          next_ctrl[`BIT_SHIP_AUTO]  = 1'b0;
        end
      end else if (src_connect || src_remove) begin
        next_ctrl[`BIT_SWITCH_OFF] = 1'b0;
      end
    end
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl <= `RST_THERM_CTRL;
    end else if (CE) begin
      ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------------------------------------
  // float voltage and charge current storage
  // ----------------------------------------------------------------------
  wire [7:0] float_q;
  wire [7:0] curr_q;

  reg_store #(.RST_VAL(`RST_FLOAT_VOLT), .WMASK(8'hFF)) u_float (
    .clk      (CORE_CLK),
    .rstn     (RSTN),
    .ce       (CE),
    .soft_rst (soft_rst),
    .wr       (wr_float),
    .wdata    (WDATA),
    .q        (float_q)
  );

  reg_store #(.RST_VAL(`RST_CHARGE_CURR), .WMASK(`MASK_CHARGE_CURR)) u_curr (
    .clk      (CORE_CLK),
    .rstn     (RSTN),
    .ce       (CE),
    .soft_rst (soft_rst),
    .wr       (wr_curr),
    .wdata    (WDATA),
    .q        (curr_q)
  );

  // ----------------------------------------------------------------------
  // outputs and read data
  // ----------------------------------------------------------------------
  reg [7:0] rd_mux;

  // soft-reset bit never stored, so it reads zero
  always @* begin
    case (ADDR)
      `ADDR_THERM_CTRL:  rd_mux = ctrl & `MASK_THERM_CTRL;
      `ADDR_FLOAT_VOLT:  rd_mux = float_q;
      `ADDR_CHARGE_CURR: rd_mux = curr_q & `MASK_CHARGE_CURR;
      default:           rd_mux = 8'h00;
    endcase
  end

  // registered outputs
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA                        <= 8'h00;
      BATTERY_PASS_SWITCH_ON       <= 1'b0;
      SUPPLEMENT_ALLOWED           <= 1'b0;
      THERMAL_REGULATION_THRESHOLD <= 2'h2;
      FLOAT_VOLTAGE_SETTING        <= `RST_FLOAT_VOLT;
      FAST_CHARGE_CURRENT          <= 6'h10;
    end else if (CE) begin
      if (RD_EN) begin
        RDATA <= rd_mux;
      end
      // switch off and charge disable both open the pass switch
      BATTERY_PASS_SWITCH_ON <= ~ctrl[`BIT_SWITCH_OFF]
                                & ~ctrl[`BIT_CHARGE_DIS];
      SUPPLEMENT_ALLOWED <= ~ctrl[`BIT_SWITCH_OFF] & sys_low;
      THERMAL_REGULATION_THRESHOLD <= ctrl[`BIT_TREG_HI:`BIT_TREG_LO];
      FLOAT_VOLTAGE_SETTING <= float_q;
      // codes 3Dh..3Fh all clamp to the maximum
      if (curr_q[`CURR_MSB:0] >= `CURR_MAX_CODE) begin
        FAST_CHARGE_CURRENT <= `CURR_MAX_CODE;
      end else begin
        FAST_CHARGE_CURRENT <= curr_q[`CURR_MSB:0];
      end
    end
  end

endmodule // charger_control_register_bank
`default_nettype wire

/* File: verification/charger_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// ----
// port checks
// ----
module charger_checks (
  input wire logic       CORE_CLK, RSTN, CE, WR_EN, RD_EN,
  input wire logic [7:0] ADDR, WDATA, RDATA, FLOAT_VOLTAGE_SETTING,
  input wire logic       BATTERY_PASS_SWITCH_ON, SUPPLEMENT_ALLOWED,
  input wire logic [1:0] THERMAL_REGULATION_THRESHOLD,
  input wire logic [5:0] FAST_CHARGE_CURRENT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // control writes and reads
  wire logic w0f = CE && WR_EN && ADDR == 8'h0F && !WDATA[7];
  wire logic rd = CE && RD_EN;
  AST_SOFT_RESET: assert property (CE && WR_EN && ADDR == 8'h0F && WDATA[7] ##1 CE |=>
    THERMAL_REGULATION_THRESHOLD == 2'h2 && FAST_CHARGE_CURRENT == 6'h10
    && FLOAT_VOLTAGE_SETTING == 8'h00) else $error("soft reset missed");
  AST_THRESHOLD: assert property (w0f ##1 CE |=>
    THERMAL_REGULATION_THRESHOLD == $past(WDATA[6:5], 2)) else $error("threshold wrong");
  AST_SWITCH: assert property (w0f ##1 CE |=>
    BATTERY_PASS_SWITCH_ON == ($past(WDATA[1:0], 2) == 2'h0)) else $error("switch wrong");
  AST_NO_SUPPLEMENT: assert property (w0f && WDATA[1] ##1 CE |=> !SUPPLEMENT_ALLOWED)
    else $error("supplement while off");
  AST_CURRENT: assert property (CE && WR_EN && ADDR == 8'h12 ##1 CE |=>
    FAST_CHARGE_CURRENT == ($past(WDATA[5:0], 2) > 6'h3D ? 6'h3D : $past(WDATA[5:0], 2)))
    else $error("current wrong");
  AST_READ_CTRL: assert property (rd && ADDR == 8'h0F |=> (RDATA & 8'h98) == 8'h00)
    else $error("control reserved bits set");
  AST_READ_CURR: assert property (rd && ADDR == 8'h12 |=> RDATA[7:6] == 2'h0)
    else $error("current reserved bits set");
  AST_UNMAPPED: assert property (rd && ADDR != 8'h0F && ADDR != 8'h11 && ADDR != 8'h12
    |=> RDATA == 8'h00) else $error("unmapped read not zero");
endmodule // charger_checks
bind charger_control_register_bank charger_checks u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
  .CE(CE), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA),
  .FLOAT_VOLTAGE_SETTING(FLOAT_VOLTAGE_SETTING), .SUPPLEMENT_ALLOWED(SUPPLEMENT_ALLOWED),
  .BATTERY_PASS_SWITCH_ON(BATTERY_PASS_SWITCH_ON), .FAST_CHARGE_CURRENT(FAST_CHARGE_CURRENT),
  .THERMAL_REGULATION_THRESHOLD(THERMAL_REGULATION_THRESHOLD));
`default_nettype wire

/* File: verification/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----
// host side of the register port
// ----
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output var  logic       ce, wr_en, rd_en,
  output var  logic [7:0] addr, wdata
);
  initial begin
    ce = 1'h1;
    wr_en = 1'h0;
    rd_en = 1'h0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // one write, lines inverted once released
  task wr(input logic [7:0] a, d);
    @(posedge clk) #1;
    {addr, wdata, wr_en} = {a, d, 1'h1};
    @(posedge clk) #1;
    {addr, wdata, wr_en} = {~a, ~d, 1'h0};
  endtask
  // one write offered while the clock enable is low; it must not land
  task wr_frozen(input logic [7:0] a, d);
    @(posedge clk) #1;
    {ce, addr, wdata, wr_en} = {1'h0, a, d, 1'h1};
    @(posedge clk) #1;
    {ce, addr, wdata, wr_en} = {1'h1, ~a, ~d, 1'h0};
  endtask
  // one read, data taken at the answering edge
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    {addr, rd_en} = {a, 1'h1};
    @(posedge clk) #1;
    {addr, rd_en} = {~a, 1'h0};
    d = rdata;
  endtask
endmodule // host_model
`default_nettype wire

/* File: verification/charger_control_register_bank_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module charger_control_register_bank_bench;
  logic clk = 0, rstn = 0, bus_low = 0, in_low = 0, src = 1, sys_low = 0;
  wire logic ce, wr_en, rd_en, sw_on, sup;
  wire logic [7:0] addr, wdata, rdata, flt;
  wire logic [1:0] thr;
  wire logic [5:0] cur;
  int mismatches = 0, checks_done = 0, cycles = 0;
  logic [7:0] d;
  logic [23:0] rows [7] = '{24'h0F7B63, 24'h0F2020, 24'h0F0000, 24'h12FF3F,
                            24'h11A5A5, 24'h33FF00, 24'h0F4040};
  // ----
  // clock, parts, timeout
  // ----
  always #12.5 clk = ~clk;
  host_model u_host (.clk(clk), .rdata(rdata), .ce(ce), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata));
  charger_control_register_bank u_dut (.CORE_CLK(clk), .RSTN(rstn), .CE(ce), .WR_EN(wr_en),
    .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata), .BUS_BELOW_FALL(bus_low), .IN_BELOW_FALL(in_low),
    .SOURCE_VALID(src), .SYS_BELOW_BAT(sys_low), .RDATA(rdata), .BATTERY_PASS_SWITCH_ON(sw_on),
    .SUPPLEMENT_ALLOWED(sup), .THERMAL_REGULATION_THRESHOLD(thr), .FLOAT_VOLTAGE_SETTING(flt),
    .FAST_CHARGE_CURRENT(cur));
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end
  // ----
  // helpers
  // ----
  task chk(input string n, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task rdchk(input logic [7:0] a, e);
    u_host.rd(a, d);
    chk("rdata", e, d);
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    step(10);
    rstn = 1;
    rdchk(8'h0F, 8'h40);
    rdchk(8'h12, 8'h10);
    for (int i = 0; i < 7; i++) begin
      u_host.wr(rows[i][23:16], rows[i][15:8]);
      rdchk(rows[i][23:16], rows[i][7:0]);
    end
    chk("current", 8'h3D, {2'h0, cur});
    chk("float", 8'hA5, flt);
    chk("threshold", 8'h02, {6'h0, thr});
    u_host.wr_frozen(8'h0F, 8'h20);
    rdchk(8'h0F, 8'h40);
    $display("table done");
    u_host.wr(8'h0F, 8'h80);
    rdchk(8'h12, 8'h10);
    rdchk(8'h11, 8'h00);
    rdchk(8'h0F, 8'h40);
    $display("soft reset done");
    sys_low = 1;
    u_host.wr(8'h0F, 8'h41);
    step(5);
    chk("switch", 8'h00, {7'h0, sw_on});
    chk("supplement", 8'h01, {7'h0, sup});
    u_host.wr(8'h0F, 8'h42);
    step(3);
    chk("supplement", 8'h00, {7'h0, sup});
    $display("supplement done");
    u_host.wr(8'h0F, 8'h44);
    {src, bus_low} = 2'h1;
    step(8);
    rdchk(8'h0F, 8'h46);
    {src, bus_low} = 2'h2;
    step(8);
    rdchk(8'h0F, 8'h40);
    u_host.wr(8'h0F, 8'h42);
    {src, in_low} = 2'h1;
    step(8);
    rdchk(8'h0F, 8'h40);
    chk("switch", 8'h01, {7'h0, sw_on});
    $display("ship mode done");
    summarize();
  end
endmodule // charger_control_register_bank_bench
`default_nettype wire
